// [hdl/lps_regs.svh]
// Register offsets, field positions, reset values and timing counts of the LIN PHY supervisor.
`ifndef LPS_REGS_SVH
`define LPS_REGS_SVH
`define LPS_CTRL_IDX          5'h17
`define LPS_STAT_IDX          5'h18
`define LPS_MASK_IDX          5'h19
`define LPS_SYS_IDX           5'h1A
`define LPS_CTRL_FAST_BIT     0
`define LPS_CTRL_SHDB_LSB     1
`define LPS_CTRL_WUMD_BIT     3
`define LPS_STAT_WAKE_BIT     0
`define LPS_STAT_DTO_BIT      1
`define LPS_STAT_SHORT_BIT    2
`define LPS_SYS_SLEEP_BIT     0
`define LPS_CTRL_RESET        4'h0
`define LPS_STAT_RESET        3'h0
`define LPS_MASK_RESET        3'h0
`define LPS_SYS_RESET         1'h0
`define LPS_CLK_MHZ           200
`define LPS_DTO_TIME_MS       11
`define LPS_DTO_CYCLES        (`LPS_DTO_TIME_MS * 1000 * `LPS_CLK_MHZ)
`define LPS_WAKE_TIME_US      150
`define LPS_WAKE_CYCLES       (`LPS_WAKE_TIME_US * `LPS_CLK_MHZ)
`define LPS_SHDB_DIV          5
`define LPS_SHDB_CODE0        96
`define LPS_SHDB_CODE1        128
`define LPS_SHDB_CODE2        192
`define LPS_SHDB_CODE3        255
`endif

// [hdl/lps_pkg.sv]
// Types shared by the LIN PHY supervisor.
package lps_pkg;
    typedef logic [31:0] lps_word_t;
    typedef logic [2:0]  lps_flags_t;
    typedef enum logic [1:0] {
        LPS_WAKE_IDLE,
        LPS_WAKE_DOM,
        LPS_WAKE_LONG
    } lps_wake_e;
endpackage : lps_pkg

// [hdl/lps_sync.sv]
// Three-stage input synchroniser with second/third stage agreement.
`timescale 1ns/1ps
module lps_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic pclk,    // Clock.
    input  wire logic presetn, // Asynchronous reset, active low.
    input  wire logic clk_en,  // Clock enable.
    input  wire logic async_in, // Raw pin level.
    output logic      sync_out  // Filtered level.
);
    logic [2:0] stage_reg;
    logic [2:0] stage_next;
    logic       out_reg;
    logic       out_next;

    always_comb begin
        stage_next = {stage_reg[1:0], async_in};
        out_next   = out_reg;
        // The first stage only feeds the second; agreement looks at stages two and three.
        if (stage_reg[1] == stage_reg[2]) begin
            out_next = stage_reg[2];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage_reg <= {3{RESET_VAL}};
            out_reg   <= RESET_VAL;
        end else if (clk_en) begin
            stage_reg <= stage_next;
            out_reg   <= out_next;
        end
    end

    assign sync_out = out_reg;
endmodule : lps_sync

// [hdl/lps_top.sv]
// LIN PHY supervisor: wake-up detection, short and dominant time-out protection, APB registers.
`timescale 1ns/1ps
`include "lps_regs.svh"
module lps_top #(
    parameter int DTO_CYCLES  = `LPS_DTO_CYCLES,  // Dominant time-out length in pclk cycles.
    parameter int WAKE_CYCLES = `LPS_WAKE_CYCLES, // Minimum wake dominant time in pclk cycles.
    parameter int SHDB_DIV    = `LPS_SHDB_DIV     // Debounce tick divider.
) (
    input  wire logic         pclk,        // Clock, 200 MHz.
    input  wire logic         presetn,     // Asynchronous reset, active low.
    input  wire logic         clk_en,      // Freezes all state while low.
    input  wire logic         psel,        // APB select.
    input  wire logic         penable,     // APB enable.
    input  wire logic         pwrite,      // APB direction.
    input  wire logic [11:0]  paddr,       // APB byte address.
    input  wire logic [31:0]  pwdata,      // APB write data.
    output lps_pkg::lps_word_t prdata,     // APB read data.
    output logic              pready,      // APB ready.
    output logic              pslverr,     // APB error on unmapped address.
    input  wire logic         tx_data,     // Transmit data from the MCU, 0 is dominant.
    input  wire logic         bus_rx_pin,  // Bus level from the receiver, 0 is dominant.
    input  wire logic         tx_overcur,  // Overcurrent comparator of the output stage.
    output logic              tx_drive,    // Transmitter drives dominant when high.
    output logic              tx_power_en, // Transmitter power enable.
    output logic              fast_mode,   // Fast baud slope mode for the analog stage.
    output logic              wake_req,    // One-cycle wake request to the power manager.
    output logic              irq          // Level interrupt.
);
    import lps_pkg::*;

    function automatic logic [11:0] lps_addr(input logic [4:0] idx);
        lps_addr = {5'h00, idx, 2'h0};
    endfunction : lps_addr

    function automatic logic [8:0] shdb_limit(input logic [1:0] code);
        case (code)
            2'h0: shdb_limit = 9'(`LPS_SHDB_CODE0);
            2'h1: shdb_limit = 9'(`LPS_SHDB_CODE1);
            2'h2: shdb_limit = 9'(`LPS_SHDB_CODE2);
            default: shdb_limit = 9'(`LPS_SHDB_CODE3);
        endcase
    endfunction : shdb_limit

    logic bus_rx;
    logic ovc_s;

    lps_sync #(.RESET_VAL(1'b1)) u_sync_rx (
        .pclk     (pclk),
        .presetn  (presetn),
        .clk_en   (clk_en),
        .async_in (bus_rx_pin),
        .sync_out (bus_rx)
    );

    lps_sync #(.RESET_VAL(1'b0)) u_sync_ovc (
        .pclk     (pclk),
        .presetn  (presetn),
        .clk_en   (clk_en),
        .async_in (tx_overcur),
        .sync_out (ovc_s)
    );

    // Register file state.
    logic [3:0]  ctrl_reg;
    logic [3:0]  ctrl_next;
    lps_flags_t  stat_reg;
    lps_flags_t  stat_next;
    lps_flags_t  mask_reg;
    lps_flags_t  mask_next;
    logic        sleep_reg;
    logic        sleep_next;
    lps_word_t   prdata_reg;
    lps_word_t   prdata_next;
    logic        pready_reg;
    logic        pready_next;
    logic        pslverr_reg;
    logic        pslverr_next;
    logic        irq_reg;
    logic        irq_next;

    // Supervision state.
    lps_wake_e   wake_reg;
    lps_wake_e   wake_next;
    logic [31:0] wake_cnt_reg;
    logic [31:0] wake_cnt_next;
    logic        rx_prev_reg;
    logic        rx_prev_next;
    logic [31:0] dto_cnt_reg;
    logic [31:0] dto_cnt_next;
    logic [7:0]  div_cnt_reg;
    logic [7:0]  div_cnt_next;
    logic [8:0]  sh_cnt_reg;
    logic [8:0]  sh_cnt_next;
    logic        tx_drive_reg;
    logic        tx_drive_next;
    logic        tx_pwr_reg;
    logic        tx_pwr_next;
    logic        fast_reg;
    logic        fast_next;
    logic        wake_req_reg;
    logic        wake_req_next;

    logic        wr_en;
    logic        rd_en;
    logic        hit_ctrl;
    logic        hit_stat;
    logic        hit_mask;
    logic        hit_sys;
    logic        wake_evt;
    logic        short_evt;
    logic        dto_evt;
    logic        tx_fault;
    logic        tx_active;

    // One wait state: pready follows the first access edge, and a write lands at the edge that samples it.
    always_comb begin
        wr_en    = psel && penable && pwrite && pready_reg;
        rd_en    = psel && penable && !pwrite && !pready_reg;
        hit_ctrl = 1'b0;
        hit_stat = 1'b0;
        hit_mask = 1'b0;
        hit_sys  = 1'b0;
        if (paddr == lps_addr(`LPS_CTRL_IDX)) begin
            hit_ctrl = 1'b1;
        end else if (paddr == lps_addr(`LPS_STAT_IDX)) begin
            hit_stat = 1'b1;
        end else if (paddr == lps_addr(`LPS_MASK_IDX)) begin
            hit_mask = 1'b1;
        end else if (paddr == lps_addr(`LPS_SYS_IDX)) begin
            hit_sys = 1'b1;
        end
    end

    // A fault holds the transmitter off until its flag is cleared.
    assign tx_fault  = stat_reg[`LPS_STAT_SHORT_BIT] || stat_reg[`LPS_STAT_DTO_BIT];
    assign tx_active = tx_pwr_reg && !tx_fault;

    // Wake detector runs on the receiver only, so it works with the transmitter off.
    always_comb begin
        wake_next     = wake_reg;
        wake_cnt_next = wake_cnt_reg;
        rx_prev_next  = bus_rx;
        wake_evt      = 1'b0;
        case (wake_reg)
            LPS_WAKE_IDLE: begin
                wake_cnt_next = 32'h0000_0000;
                if (sleep_reg && rx_prev_reg && !bus_rx) begin
                    wake_next = LPS_WAKE_DOM;
                end
            end
            LPS_WAKE_DOM: begin
                if (bus_rx || !sleep_reg) begin
                    wake_next = LPS_WAKE_IDLE;
                end else if (wake_cnt_reg >= 32'(WAKE_CYCLES)) begin
                    if (!ctrl_reg[`LPS_CTRL_WUMD_BIT]) begin
                        wake_evt  = 1'b1;
                        wake_next = LPS_WAKE_IDLE;
                    end else begin
                        wake_next = LPS_WAKE_LONG;
                    end
                end else begin
                    wake_cnt_next = wake_cnt_reg + 32'h0000_0001;
                end
            end
            LPS_WAKE_LONG: begin
                if (!sleep_reg) begin
                    wake_next = LPS_WAKE_IDLE;
                end else if (bus_rx) begin
                    wake_evt  = 1'b1;
                    wake_next = LPS_WAKE_IDLE;
                end
            end
            default: begin
                wake_next = LPS_WAKE_IDLE;
            end
        endcase
    end

    // Short debounce counts ticks of a divided clock standing in for the fast oscillator over five.
    always_comb begin
        div_cnt_next = div_cnt_reg;
        sh_cnt_next  = sh_cnt_reg;
        short_evt    = 1'b0;
        if (tx_active && tx_drive_reg && ovc_s && bus_rx) begin
            if (div_cnt_reg >= 8'(SHDB_DIV - 1)) begin
                div_cnt_next = 8'h00;
                if (sh_cnt_reg >= shdb_limit(ctrl_reg[`LPS_CTRL_SHDB_LSB +: 2])) begin
                    short_evt = 1'b1;
                end else begin
                    sh_cnt_next = sh_cnt_reg + 9'h001;
                end
            end else begin
                div_cnt_next = div_cnt_reg + 8'h01;
            end
        end else begin
            div_cnt_next = 8'h00;
            sh_cnt_next  = 9'h000;
        end
    end

    // Counts our own dominant drive only; an externally held bus never advances it.
    always_comb begin
        dto_cnt_next = 32'h0000_0000;
        dto_evt      = 1'b0;
        if (tx_drive_reg) begin
            if (dto_cnt_reg >= 32'(DTO_CYCLES)) begin
                dto_evt      = 1'b1;
                dto_cnt_next = dto_cnt_reg;
            end else begin
                dto_cnt_next = dto_cnt_reg + 32'h0000_0001;
            end
        end
    end

    // Transmitter control.
    always_comb begin
        tx_pwr_next   = tx_pwr_reg;
        wake_req_next = wake_evt;
        if (sleep_reg && !wake_evt) begin
            tx_pwr_next = 1'b0;
        end else if (wake_evt) begin
            tx_pwr_next = 1'b1;
        end else begin
            tx_pwr_next = 1'b1;
        end
        if (short_evt || dto_evt || tx_fault) begin
            tx_pwr_next = 1'b0;
        end
        tx_drive_next = tx_pwr_next && !tx_data;
        fast_next     = ctrl_reg[`LPS_CTRL_FAST_BIT];
    end

    // Register file with sticky flags; a set in the same cycle beats a clear.
    always_comb begin
        ctrl_next    = ctrl_reg;
        mask_next    = mask_reg;
        sleep_next   = sleep_reg;
        stat_next    = stat_reg;
        prdata_next  = prdata_reg;
        pready_next  = psel && penable && !pready_reg;
        pslverr_next = psel && penable && !pready_reg && !(hit_ctrl || hit_stat || hit_mask || hit_sys);
        if (wr_en) begin
            if (hit_ctrl) begin
                ctrl_next = pwdata[3:0];
            end else if (hit_stat) begin
                stat_next = stat_reg & ~pwdata[2:0];
            end else if (hit_mask) begin
                mask_next = pwdata[2:0];
            end else if (hit_sys) begin
                sleep_next = pwdata[`LPS_SYS_SLEEP_BIT];
            end
        end else if (rd_en) begin
            if (hit_ctrl) begin
                prdata_next = {28'h0000000, ctrl_reg};
            end else if (hit_stat) begin
                prdata_next = {29'h00000000, stat_reg};
            end else if (hit_mask) begin
                prdata_next = {29'h00000000, mask_reg};
            end else if (hit_sys) begin
                prdata_next = {31'h00000000, sleep_reg};
            end else begin
                prdata_next  = 32'h0000_0000;
            end
        end
        // Wake leaves sleep so the power manager and transmitter agree.
        if (wake_evt) begin
            sleep_next = 1'b0;
        end
        if (wake_evt) begin
            stat_next[`LPS_STAT_WAKE_BIT] = 1'b1;
        end
        if (dto_evt) begin
            stat_next[`LPS_STAT_DTO_BIT] = 1'b1;
        end
        if (short_evt) begin
            stat_next[`LPS_STAT_SHORT_BIT] = 1'b1;
        end
        irq_next = |(stat_next & mask_next);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg     <= `LPS_CTRL_RESET;
            stat_reg     <= `LPS_STAT_RESET;
            mask_reg     <= `LPS_MASK_RESET;
            sleep_reg    <= `LPS_SYS_RESET;
            prdata_reg   <= 32'h0000_0000;
            pready_reg   <= 1'b0;
            pslverr_reg  <= 1'b0;
            irq_reg      <= 1'b0;
            wake_reg     <= LPS_WAKE_IDLE;
            wake_cnt_reg <= 32'h0000_0000;
            rx_prev_reg  <= 1'b1;
            dto_cnt_reg  <= 32'h0000_0000;
            div_cnt_reg  <= 8'h00;
            sh_cnt_reg   <= 9'h000;
            tx_drive_reg <= 1'b0;
            tx_pwr_reg   <= 1'b0;
            fast_reg     <= 1'b0;
            wake_req_reg <= 1'b0;
        end else if (clk_en) begin
            ctrl_reg     <= ctrl_next;
            stat_reg     <= stat_next;
            mask_reg     <= mask_next;
            sleep_reg    <= sleep_next;
            prdata_reg   <= prdata_next;
            pready_reg   <= pready_next;
            pslverr_reg  <= pslverr_next;
            irq_reg      <= irq_next;
            wake_reg     <= wake_next;
            wake_cnt_reg <= wake_cnt_next;
            rx_prev_reg  <= rx_prev_next;
            dto_cnt_reg  <= dto_cnt_next;
            div_cnt_reg  <= div_cnt_next;
            sh_cnt_reg   <= sh_cnt_next;
            tx_drive_reg <= tx_drive_next;
            tx_pwr_reg   <= tx_pwr_next;
            fast_reg     <= fast_next;
            wake_req_reg <= wake_req_next;
        end
    end

    assign prdata      = prdata_reg;
    assign pready      = pready_reg;
    assign pslverr     = pslverr_reg;
    assign tx_drive    = tx_drive_reg;
    assign tx_power_en = tx_pwr_reg;
    assign fast_mode   = fast_reg;
    assign wake_req    = wake_req_reg;
    assign irq         = irq_reg;
endmodule : lps_top

// [testbench/lps_top_monitor.sv]
// Port-level assertions for the LIN PHY supervisor.
`timescale 1ns/1ps
module lps_top_monitor #(
    parameter int DTO_CYCLES = 50, // Dominant time-out length.
    parameter int SHDB_DIV   = 5   // Debounce tick divider.
) (
    input wire logic pclk,        // Clock.
    input wire logic presetn,     // Reset, active low.
    input wire logic psel,        // APB select.
    input wire logic penable,     // APB enable.
    input wire logic pwrite,      // APB direction.
    input wire logic pready,      // APB ready.
    input wire logic pslverr,     // APB error.
    input wire logic bus_rx_pin,  // Bus level.
    input wire logic tx_overcur,  // Overcurrent.
    input wire logic tx_drive,    // Dominant drive.
    input wire logic tx_power_en, // Transmitter power.
    input wire logic fast_mode,   // Fast baud mode.
    input wire logic wake_req,    // Wake pulse.
    input wire logic irq          // Interrupt.
);
    // The raw pins skip the synchroniser, so the run bound carries some slack.
    localparam int SHORT_MAX = (255 + 1) * SHDB_DIV + 12;
    int dom_reg;
    int dom_next;
    int short_reg;
    int short_next;

    always_comb begin
        dom_next   = tx_drive ? dom_reg + 1 : 0;
        short_next = (tx_drive && tx_overcur && bus_rx_pin) ? short_reg + 1 : 0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dom_reg   <= 0;
            short_reg <= 0;
        end else begin
            dom_reg   <= dom_next;
            short_reg <= short_next;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_taken;
        psel && penable && !pready;
    endsequence
    sequence s_answer;
        pready && psel && penable ##1 !pready;
    endsequence

    ready_after_req_a: assert property (s_taken |=> s_answer)
        else $error("ready missing after access");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    irq_fall_write_a: assert property ($fell(irq) |-> ($past(psel && penable && pwrite) ||
        $past(psel && penable && pwrite, 2))) else $error("irq fell without a write");
    drive_needs_power_a: assert property (tx_drive |-> tx_power_en)
        else $error("drive while powered down");
    wake_power_a: assert property (wake_req |-> ##[0:2] tx_power_en ##1 (!wake_req)[*2])
        else $error("wake without power or pulse too long");
    fast_after_write_a: assert property ($changed(fast_mode) |-> ($past(psel && penable && pwrite) ||
        $past(psel && penable && pwrite, 2))) else $error("fast mode changed alone");
    short_limit_a: assert property (short_reg <= SHORT_MAX)
        else $error("short not cut off in time");
    dto_limit_a: assert property (dom_reg <= DTO_CYCLES + 4)
        else $error("dominant drive not cut off in time");
    power_rise_cause_a: assert property ($rose(tx_power_en) |-> (!$past(presetn) || !$past(presetn, 2) ||
        wake_req || $past(wake_req) || $past(psel && pwrite) || $past(psel && pwrite, 2)))
        else $error("power returned without cause");
endmodule : lps_top_monitor

bind lps_top lps_top_monitor #(.DTO_CYCLES(DTO_CYCLES), .SHDB_DIV(SHDB_DIV)) u_lps_top_monitor (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .pslverr(pslverr), .bus_rx_pin(bus_rx_pin), .tx_overcur(tx_overcur),
    .tx_drive(tx_drive), .tx_power_en(tx_power_en), .fast_mode(fast_mode), .wake_req(wake_req), .irq(irq));

// [testbench/lps_bus_node.sv]
// Model of the LIN bus: pull-up, another node, and a short to battery.
`timescale 1ns/1ps
module lps_bus_node (
    input  wire logic tx_drive,   // Our stage drives dominant.
    input  wire logic ext_dom,    // Another node pulls dominant.
    input  wire logic short_en,   // Bus shorted to battery.
    output logic      bus_rx_pin, // Bus level, 0 is dominant.
    output logic      tx_overcur  // Output stage overcurrent.
);
    always_comb begin
        if (short_en) begin
            bus_rx_pin = 1'b1;
            tx_overcur = tx_drive;
        end else begin
            // Released bus returns to recessive through the pull-up.
            bus_rx_pin = ~(tx_drive | ext_dom);
            tx_overcur = 1'b0;
        end
    end
endmodule : lps_bus_node

// [testbench/lin_phy_supervisor_tb.sv]
// Self-checking bench for the LIN PHY supervisor.
`timescale 1ns/1ps
`include "lps_regs.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module lin_phy_supervisor_tb;
    import lps_pkg::*;
    localparam int DTO  = 3000;
    localparam int WAKE = 20;
    localparam int DIV  = 5;
    localparam logic [11:0] A_CTRL = {5'h00, `LPS_CTRL_IDX, 2'b00};
    localparam logic [11:0] A_STAT = {5'h00, `LPS_STAT_IDX, 2'b00};
    localparam logic [11:0] A_MASK = {5'h00, `LPS_MASK_IDX, 2'b00};
    localparam logic [11:0] A_SYS  = {5'h00, `LPS_SYS_IDX, 2'b00};
    localparam logic [11:0] A_BAD  = 12'h070;
    logic pclk, presetn, clk_en, psel, penable, pwrite, tx_data, ext_dom, short_en;
    logic [11:0] paddr;
    logic [31:0] pwdata, v, seed;
    lps_word_t   prdata;
    logic pready, pslverr, bus_rx_pin, tx_overcur, tx_drive, tx_power_en, fast_mode, wake_req, irq, p1, p2;
    logic [33:0] notes[$];
    logic [33:0] cur;
    int num_errors, compares, n, got, i, m, lo;
    int lims[4] = '{`LPS_SHDB_CODE0, `LPS_SHDB_CODE1, `LPS_SHDB_CODE2, `LPS_SHDB_CODE3};

    lps_top #(.DTO_CYCLES(DTO), .WAKE_CYCLES(WAKE), .SHDB_DIV(DIV)) u_lps_top (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_data(tx_data), .bus_rx_pin(bus_rx_pin), .tx_overcur(tx_overcur),
        .tx_drive(tx_drive), .tx_power_en(tx_power_en), .fast_mode(fast_mode), .wake_req(wake_req), .irq(irq));
    lps_bus_node u_lps_bus_node (.tx_drive(tx_drive), .ext_dom(ext_dom), .short_en(short_en),
        .bus_rx_pin(bus_rx_pin), .tx_overcur(tx_overcur));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xorshift

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [33:0] note);
        @(posedge pclk);
        notes.push_back(note);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, {2'b00, 32'h0000_0000});
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000, {2'b10, e});
    endtask : rd

    task automatic test_end(input string name);
        $display("test %s finished", name);
    endtask : test_end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out

    // Every answer on the bus consumes the oldest note of the driver.
    always @(posedge pclk) begin
        if (pready === 1'b1) begin
            cur = (notes.size() > 0) ? notes.pop_front() : 34'h3_FFFF_FFFF;
            `CHK(pslverr, cur[32])
            if (cur[33]) `CHK(prdata, cur[31:0])
        end
    end

    initial begin
        repeat (40000) @(posedge pclk);
        num_errors++;
        close_out();
    end

    initial begin
        {presetn, psel, penable, pwrite, ext_dom, short_en} = 6'h00;
        {clk_en, tx_data} = 2'h3;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        seed = 32'h0000_0017;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        `CHK(tx_power_en, 1'b1)
        foreach (lims[k]) rd(A_CTRL + 12'(4 * k), 32'h0000_0000);
        apb(1'b0, A_BAD, 32'h0000_0000, {2'b11, 32'h0000_0000});
        apb(1'b1, A_BAD, xorshift(), {2'b01, 32'h0000_0000});
        for (i = 0; i < 4; i++) begin
            v = xorshift();
            wr(A_CTRL, v);
            rd(A_CTRL, {28'h000_0000, v[3:0]});
            repeat (2) @(posedge pclk);
            `CHK(fast_mode, v[0])
        end
        wr(A_MASK, 32'hFFFF_FFFF);
        rd(A_MASK, 32'h0000_0007);
        {p1, p2} = 2'h3;
        for (i = 0; i < 24; i++) begin
            @(posedge pclk);
            `CHK(tx_drive, ~p2)
            v = xorshift();
            tx_data <= v[0];
            p2 = p1;
            p1 = v[0];
        end
        tx_data <= 1'b1;
        test_end("registers");
        ext_dom <= 1'b1;
        repeat (DTO + 200) @(posedge pclk);
        ext_dom <= 1'b0;
        rd(A_STAT, 32'h0000_0000);
        tx_data <= 1'b0;
        n = 0;
        while (irq !== 1'b1) begin @(posedge pclk); n++; end
        `CHK(n >= DTO && n <= DTO + 6, 1'b1)
        rd(A_STAT, 32'h0000_0002);
        wr(A_STAT, 32'h0000_0000);
        repeat (50) @(posedge pclk);
        `CHK(tx_power_en, 1'b0)
        rd(A_STAT, 32'h0000_0002);
        tx_data <= 1'b1;
        wr(A_STAT, 32'h0000_0002);
        rd(A_STAT, 32'h0000_0000);
        `CHK(tx_power_en, 1'b1)
        test_end("dominant timeout");
        short_en <= 1'b1;
        repeat (1400) @(posedge pclk);
        rd(A_STAT, 32'h0000_0000);
        for (i = 0; i < 4; i++) begin
            wr(A_CTRL, {29'h0000_0000, i[1:0], 1'b0});
            tx_data <= 1'b0;
            n = 0;
            while (irq !== 1'b1) begin @(posedge pclk); n++; end
            `CHK(n >= (lims[i] + 1) * DIV && n <= (lims[i] + 1) * DIV + 12, 1'b1)
            repeat (2) @(posedge pclk);
            `CHK(tx_power_en, 1'b0)
            rd(A_STAT, 32'h0000_0004);
            tx_data <= 1'b1;
            wr(A_STAT, 32'h0000_0004);
        end
        short_en <= 1'b0;
        test_end("short");
        wr(A_MASK, 32'h0000_0000);
        for (m = 0; m < 2; m++) begin
            wr(A_CTRL, {28'h000_0000, m[0], 3'h0});
            wr(A_SYS, 32'h0000_0001);
            tx_data <= 1'b0;
            repeat (4) @(posedge pclk);
            `CHK({tx_power_en, tx_drive}, 2'h0)
            tx_data <= 1'b1;
            ext_dom <= 1'b1;
            repeat (WAKE - 6) @(posedge pclk);
            ext_dom <= 1'b0;
            rd(A_STAT, 32'h0000_0000);
            ext_dom <= 1'b1;
            got = 0;
            for (n = 0; n < WAKE + 40; n++) begin
                @(posedge pclk);
                if (n == WAKE + 15) ext_dom <= 1'b0;
                if (wake_req === 1'b1) got = n;
            end
            lo = (m == 1) ? WAKE + 16 : WAKE;
            `CHK(got >= lo && got <= lo + 10, 1'b1)
            rd(A_STAT, 32'h0000_0001);
            rd(A_SYS, 32'h0000_0000);
            `CHK({tx_power_en, irq}, 2'h2)
            wr(A_MASK, 32'h0000_0001);
            repeat (3) @(posedge pclk);
            `CHK(irq, 1'b1)
            wr(A_STAT, 32'h0000_0001);
            repeat (3) @(posedge pclk);
            `CHK(irq, 1'b0)
            wr(A_MASK, 32'h0000_0000);
        end
        test_end("wake");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(A_CTRL, 32'h0000_0000);
        test_end("second reset");
        close_out();
    end
endmodule : lin_phy_supervisor_tb
